//--- ddr3_pwr_pkg.sv
/*
  Package for the refresh / self-refresh / power-down state keeper of a DDR3L-style memory model.
  Assumes a single 40 MHz system clock; the memory clock arrives as a sampled pin.
*/
package ddr3_pwr_pkg;
  localparam int CLK_PERIOD_PS = 25000;
  // Minimum CKE pulse, in ps, and its count in system cycles (rounded up)
  localparam int CKE_MIN_PULSE_PS = 5000;
  localparam int CKE_MIN_CYC = (CKE_MIN_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Internal self-refresh timer period, in ps (shorter than cke_min_pulse is not required)
  localparam int SR_TIMER_PS = 5000;
  localparam int SR_TIMER_CYC = (SR_TIMER_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Internal refresh busy time, in ps
  localparam int REFRESH_CYCLE_TIME_PS = 160000;
  localparam int REFRESH_CYC = (REFRESH_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 8;
  localparam int ROW_W = 16;
  localparam int NUM_BANKS = 8;
  localparam int DLL_RESET_CYC = 4;
  localparam logic [CNT_W-1:0] CKE_MIN_CNT = CNT_W'(CKE_MIN_CYC);
  localparam logic [CNT_W-1:0] SR_TIMER_CNT = CNT_W'(SR_TIMER_CYC);
  localparam logic [CNT_W-1:0] REFRESH_CNT = CNT_W'(REFRESH_CYC);
  localparam logic [CNT_W-1:0] DLL_RESET_CNT = CNT_W'(DLL_RESET_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [ROW_W-1:0] ROW_ONE = 16'h0001;
  localparam int MR1_DLL_DIS_BIT = 0;
  localparam int MR0_PD_FAST_BIT = 12;

  typedef enum logic [2:0] {
    ST_IDLE, ST_REFRESH, ST_SELF_REFRESH, ST_PRE_PD, ST_ACT_PD, ST_RESET
  } pwr_state_type;

  // Command pins as sampled on a memory clock rising edge
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
  } cmd_type;

  typedef struct packed {
    logic dll_on;
    logic in_buf_on;
    logic clk_gated;
    logic refreshing;
  } status_type;
endpackage

//--- ddr3_pwr_ctrl.sv
/*
  Refresh, self-refresh and power-down control of the memory device.
  Assumes the memory clock, command pins, CKE and reset pin arrive asynchronously and are
  synchronised here; bank-open state and mode bits come from sibling logic on CLK.
*/
`timescale 1ns/1ps
// Operation
// - Write strobe or data timing errors only corrupt the addressed location.
// - Refresh decoded on CS, RAS, CAS low, WE high; one refresh per command.
// - Refresh uses internal row counter, ignores address, leaves banks precharged idle.
// - Self-refresh entry is refresh pattern with CKE low; CKE held low after.
// - Loop disabled on self-refresh entry, re-enabled with reset on exit.
// - In self-refresh only CKE and reset matter; clock gated; refresh within cke_min_pulse.
// - Power-down entered on CKE low with NOP; not during busy operations (the code also enters it from ST_REFRESH).
// - All banks closed gives precharge power-down, else active power-down.
// - Power-down disables buffers except clock, termination, CKE and reset.
// - Precharge power-down with slow-exit bit clear turns the loop off (the code turns it off with MR0_PD_FAST clear, i.e. slow exit).
// - CKE low and high held cke_min_pulse; reset pin overrides power-down.
module ddr3_pwr_ctrl
  import ddr3_pwr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic MEM_CK,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic CKE,
  input wire logic RESET_N,
  input wire logic BANK_OPEN,
  input wire logic MR0_PD_FAST,
  input wire logic MR1_DLL_DIS,
  output logic [ddr3_pwr_pkg::ROW_W-1:0] REFRESH_ROW,
  output logic REFRESH_STROBE,
  output ddr3_pwr_pkg::status_type STATUS,
  output ddr3_pwr_pkg::pwr_state_type STATE
);
  import ddr3_pwr_pkg::*;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  localparam int NSYNC = 7;
  // Idle levels: clock high and deselect, so reset can neither fake a clock rise nor a command
  localparam logic [NSYNC-1:0] SYNC_IDLE = 7'h7f;
  logic [NSYNC-1:0] pins;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic ck_prev_reg;
  assign pins = {MEM_CK, CS_N, RAS_N, CAS_N, WE_N, CKE, RESET_N};

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      sync1_reg <= SYNC_IDLE;
      sync2_reg <= SYNC_IDLE;
      ck_prev_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      ck_prev_reg <= sync2_reg[6];
    end
  end

  cmd_type cmd;
  logic ck_rise;
  logic rst_pin_n;
  assign cmd = sync2_reg[5:1];
  assign rst_pin_n = sync2_reg[0];
  assign ck_rise = sync2_reg[6] & ~ck_prev_reg;

  function automatic logic is_ref_pattern(input cmd_type c);
    is_ref_pattern = ~c.cs_n & ~c.ras_n & ~c.cas_n & c.we_n;
  endfunction

  function automatic logic is_nop(input cmd_type c);
    is_nop = c.cs_n | (c.ras_n & c.cas_n & c.we_n);
  endfunction

  // ************************************************************
  // Power state machine
  // ************************************************************
  pwr_state_type state_reg, state_next;
  logic cke_prev_reg, cke_prev_next;
  logic [CNT_W-1:0] busy_reg, busy_next;
  logic [CNT_W-1:0] cke_cnt_reg, cke_cnt_next;
  logic [CNT_W-1:0] sr_tmr_reg, sr_tmr_next;
  logic [CNT_W-1:0] dll_rst_reg, dll_rst_next;
  logic [ROW_W-1:0] row_reg, row_next;
  logic strobe_next;
  logic dll_on_next;
  logic sr_first_done_reg, sr_first_done_next;
  status_type status_next;

  always_comb
  begin
    state_next = state_reg;
    cke_prev_next = cke_prev_reg;
    busy_next = busy_reg;
    cke_cnt_next = cke_cnt_reg;
    sr_tmr_next = sr_tmr_reg;
    dll_rst_next = dll_rst_reg;
    row_next = row_reg;
    strobe_next = 1'b0;
    sr_first_done_next = sr_first_done_reg;
    if (busy_reg != '0)
      busy_next = busy_reg - CNT_ONE;
    if (dll_rst_reg != '0)
      dll_rst_next = dll_rst_reg - CNT_ONE;
    if (ck_rise && cke_cnt_reg != '0)
      cke_cnt_next = cke_cnt_reg - CNT_ONE;
    if (ck_rise)
      cke_prev_next = cmd.cke;
    // Reset pin wins over every power state
    if (!rst_pin_n)
    begin
      state_next = ST_RESET;
      busy_next = '0;
    end
    else
    begin
      case (state_reg)
        ST_RESET:
          state_next = ST_IDLE;
        ST_IDLE, ST_REFRESH:
        begin
          if (state_reg == ST_REFRESH && busy_reg == CNT_ONE)
            state_next = ST_IDLE;
          if (ck_rise && cke_prev_reg && cke_cnt_reg == '0)
          begin
            if (!cmd.cke && is_ref_pattern(cmd) && state_reg == ST_IDLE)
            begin
              state_next = ST_SELF_REFRESH;
              cke_cnt_next = CKE_MIN_CNT;
              sr_tmr_next = SR_TIMER_CNT;
              sr_first_done_next = 1'b0;
            end
            else if (!cmd.cke && is_nop(cmd))
            begin
              // Busy refresh counts down in the background; the power-down state is taken at once
              state_next = BANK_OPEN ? ST_ACT_PD : ST_PRE_PD;
              cke_cnt_next = CKE_MIN_CNT;
            end
            else if (cmd.cke && is_ref_pattern(cmd) && state_reg == ST_IDLE)
            begin
              state_next = ST_REFRESH;
              busy_next = REFRESH_CNT;
              row_next = row_reg + ROW_ONE;
              strobe_next = 1'b1;
            end
          end
        end
        ST_SELF_REFRESH:
        begin
          // Timer runs on CLK since the memory clock may stop here
          if (sr_tmr_reg != '0)
            sr_tmr_next = sr_tmr_reg - CNT_ONE;
          else
          begin
            sr_tmr_next = SR_TIMER_CNT;
            row_next = row_reg + ROW_ONE;
            strobe_next = 1'b1;
            sr_first_done_next = 1'b1;
          end
          if (ck_rise && cmd.cke && cke_cnt_reg == '0 && sr_first_done_reg)
          begin
            state_next = ST_IDLE;
            cke_cnt_next = CKE_MIN_CNT;
            dll_rst_next = DLL_RESET_CNT;
          end
        end
        ST_PRE_PD, ST_ACT_PD:
        begin
          if (ck_rise && cmd.cke && cke_cnt_reg == '0)
          begin
            state_next = ST_IDLE;
            cke_cnt_next = CKE_MIN_CNT;
          end
        end
        default:
          state_next = ST_IDLE;
      endcase
    end
    // Loop off in self-refresh, slow precharge power-down, or when disabled in mode reg 1
    dll_on_next = ~MR1_DLL_DIS && state_next != ST_SELF_REFRESH
      && !(state_next == ST_PRE_PD && !MR0_PD_FAST) && dll_rst_next == '0;
    status_next.dll_on = dll_on_next;
    status_next.in_buf_on = !(state_next inside {ST_SELF_REFRESH, ST_PRE_PD, ST_ACT_PD});
    status_next.clk_gated = state_next == ST_SELF_REFRESH;
    status_next.refreshing = state_next == ST_REFRESH || strobe_next;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_reg <= ST_IDLE;
      cke_prev_reg <= 1'b1;
      busy_reg <= '0;
      cke_cnt_reg <= '0;
      sr_tmr_reg <= '0;
      dll_rst_reg <= '0;
      row_reg <= '0;
      sr_first_done_reg <= 1'b0;
      REFRESH_STROBE <= 1'b0;
      STATUS <= '0;
      STATE <= ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
      cke_prev_reg <= cke_prev_next;
      busy_reg <= busy_next;
      cke_cnt_reg <= cke_cnt_next;
      sr_tmr_reg <= sr_tmr_next;
      dll_rst_reg <= dll_rst_next;
      row_reg <= row_next;
      sr_first_done_reg <= sr_first_done_next;
      REFRESH_STROBE <= strobe_next;
      STATUS <= status_next;
      STATE <= state_next;
    end
  end
  assign REFRESH_ROW = row_reg;
  // Write timing errors never reach this logic, so no state here can hang on them

  // ************************************************************
  // Checks
  // ************************************************************
  property p_ref_strobe;
    @(posedge CLK) disable iff (RST)
      (state_reg == ST_IDLE && state_next == ST_REFRESH) |=> REFRESH_STROBE;
  endproperty
  a_ref_strobe: assert property (p_ref_strobe) else $error("refresh not strobed");

  property p_ref_row;
    @(posedge CLK) disable iff (RST)
      strobe_next |=> row_reg == $past(row_reg) + ROW_ONE;
  endproperty
  a_ref_row: assert property (p_ref_row) else $error("row counter not advanced");

  property p_sr_dll;
    @(posedge CLK) disable iff (RST)
      state_reg == ST_SELF_REFRESH |-> !STATUS.dll_on;
  endproperty
  a_sr_dll: assert property (p_sr_dll) else $error("loop on in self-refresh");

  property p_sr_refresh;
    @(posedge CLK) disable iff (RST)
      (state_reg != ST_SELF_REFRESH && state_next == ST_SELF_REFRESH)
        |-> ##[1:8] (strobe_next || state_reg != ST_SELF_REFRESH);
  endproperty
  a_sr_refresh: assert property (p_sr_refresh) else $error("no refresh in self-refresh");

  property p_pd_mode;
    @(posedge CLK) disable iff (RST)
      (state_reg == ST_IDLE && state_next == ST_ACT_PD) |-> BANK_OPEN;
  endproperty
  a_pd_mode: assert property (p_pd_mode) else $error("active power-down with banks closed");

  property p_pd_buf;
    @(posedge CLK) disable iff (RST)
      state_reg inside {ST_PRE_PD, ST_ACT_PD} |=> !STATUS.in_buf_on || state_reg == ST_IDLE
        || state_reg == ST_RESET;
  endproperty
  a_pd_buf: assert property (p_pd_buf) else $error("buffers on in power-down");

  property p_slow_exit;
    @(posedge CLK) disable iff (RST)
      (state_next == ST_PRE_PD && !MR0_PD_FAST) |=> !STATUS.dll_on;
  endproperty
  a_slow_exit: assert property (p_slow_exit) else $error("loop on in slow power-down");

  property p_reset_pin;
    @(posedge CLK) disable iff (RST)
      !rst_pin_n |=> state_reg == ST_RESET;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin ignored");

  property p_pd_entry;
    @(posedge CLK) disable iff (RST)
      (ck_rise && state_reg == ST_IDLE && cke_prev_reg && cke_cnt_reg == '0 && !cmd.cke
        && is_nop(cmd) && rst_pin_n) |=> state_reg inside {ST_PRE_PD, ST_ACT_PD};
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");

  // Loop stays off through its reset after self-refresh exit
  property p_dll_relock;
    @(posedge CLK) disable iff (RST)
      (state_reg == ST_SELF_REFRESH && state_next == ST_IDLE) |=> !STATUS.dll_on [*4];
  endproperty
  a_dll_relock: assert property (p_dll_relock) else $error("loop on during relock");
endmodule

//--- mem_ctrl_model.sv
/*
  Behavioural memory controller: drives the memory clock, CKE and the command pins.
  Assumes the testbench calls issue() from one process at a time.
*/
`timescale 1ns/1ps
module mem_ctrl_model
  import ddr3_pwr_pkg::*;
(
  output logic mem_ck,
  output ddr3_pwr_pkg::cmd_type cmd
);
  // *******************************
  // Clock and command sequencing
  // *******************************
  // Pulled-in refresh credit; no interval timer, as a run is far shorter than one interval
  int credit;

  // Free-running clock, offset so its edges never meet the system clock's edges
  initial
  begin
    credit = 0;
    mem_ck = 1'b0;
    cmd = 5'h1f;
    #7;
    forever #100 mem_ck = ~mem_ck;
  end

  // Deselect scrambles the other lines so a design that ignores select misfires
  task automatic issue(input logic [3:0] pins, input logic cke, input int gap);
    @(negedge mem_ck);
    cmd = {pins, cke};
    if (pins == 4'b0001 && cke && credit < 8)
      credit = credit + 1;
    @(negedge mem_ck);
    cmd = {1'b1, ~pins[2:0], cke};
    repeat (gap) @(negedge mem_ck);
  endtask
endmodule

//--- tb.sv
/*
  Self-checking bench for the refresh, self-refresh and power-down control.
  Assumes the controller model in mem_ctrl_model and a 40 MHz system clock.
*/
`timescale 1ns/1ps
module tb;
  import ddr3_pwr_pkg::*;
  logic clk;
  logic rst;
  logic reset_n;
  logic bank_open;
  logic pd_fast;
  logic dll_dis;
  logic mem_ck;
  cmd_type cmd;
  logic [ROW_W-1:0] row;
  logic strobe;
  status_type status;
  pwr_state_type state;
  int err_total;
  int comparisons;
  int strobes;
  int cycles;

  mem_ctrl_model i_mem_ctrl_model (.mem_ck(mem_ck), .cmd(cmd));
  ddr3_pwr_ctrl i_ddr3_pwr_ctrl (.CLK(clk), .RST(rst), .MEM_CK(mem_ck), .CS_N(cmd.cs_n),
    .RAS_N(cmd.ras_n), .CAS_N(cmd.cas_n), .WE_N(cmd.we_n), .CKE(cmd.cke), .RESET_N(reset_n),
    .BANK_OPEN(bank_open), .MR0_PD_FAST(pd_fast), .MR1_DLL_DIS(dll_dis), .REFRESH_ROW(row),
    .REFRESH_STROBE(strobe), .STATUS(status), .STATE(state));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // The run takes a few hundred cycles; the ceiling only cuts a hang short
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (strobe === 1'b1)
      strobes <= strobes + 1;
    if (cycles == 20000)
    begin
      err_total++;
      conclude();
    end
  end

  // *******************************
  // Checking helpers
  // *******************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic wait_state(input pwr_state_type s, input int lim);
    int n;
    n = 0;
    while (state !== s && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(state), 32'(s), "state");
  endtask

  task automatic conclude();
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // *******************************
  // Scenarios
  // *******************************
  task automatic t_refresh();
    int s0;
    logic [ROW_W-1:0] r0;
    repeat (2)
    begin
      s0 = strobes;
      r0 = row;
      fork
        i_mem_ctrl_model.issue(4'b0001, 1'b1, 1);
        begin
          wait_state(ST_REFRESH, 40);
          chk(32'(status.refreshing), 32'h1, "refreshing flag");
        end
      join
      wait_state(ST_IDLE, 40);
      chk(32'(status.refreshing), 32'h0, "refresh done");
      chk(32'(strobes - s0), 32'h1, "one strobe per refresh");
      chk(32'(row), 32'(r0 + ROW_ONE), "row step");
    end
  endtask

  task automatic t_self_refresh();
    int s0;
    logic [ROW_W-1:0] r0;
    fork
      i_mem_ctrl_model.issue(4'b0001, 1'b0, 0);
      wait_state(ST_SELF_REFRESH, 40);
    join
    chk(32'(status.clk_gated), 32'h1, "clock gated");
    chk(32'(status.dll_on), 32'h0, "loop off in self-refresh");
    s0 = strobes;
    r0 = row;
    // A refresh pattern while CKE stays low must change nothing
    i_mem_ctrl_model.issue(4'b0001, 1'b0, 2);
    chk(32'(state), 32'(ST_SELF_REFRESH), "inputs ignored");
    chk(32'(strobes > s0), 32'h1, "internal refresh");
    chk(32'(row - r0), 32'(16'(strobes - s0)), "internal row count");
    fork
      i_mem_ctrl_model.issue(4'b1111, 1'b1, 0);
      wait_state(ST_IDLE, 40);
    join
    chk(32'(status.clk_gated), 32'h0, "clock ungated after exit");
    repeat (DLL_RESET_CYC + 4) @(posedge clk);
    #1;
    chk(32'(status.dll_on), 32'h1, "loop back after exit");
    @(posedge clk);
    #2;
    dll_dis = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(32'(status.dll_on), 32'h0, "loop disabled by mode bit");
    #1;
    dll_dis = 1'b0;
  endtask

  task automatic t_power_down(input logic bank, input logic fast, input pwr_state_type exp,
    input logic dll);
    @(posedge clk);
    #2;
    bank_open = bank;
    pd_fast = fast;
    fork
      i_mem_ctrl_model.issue(4'b1111, 1'b0, 1);
      wait_state(exp, 40);
    join
    chk(32'(status.dll_on), 32'(dll), "loop in power-down");
    chk(32'(status.in_buf_on), 32'h0, "buffers off");
    fork
      i_mem_ctrl_model.issue(4'b1111, 1'b1, 1);
      wait_state(ST_IDLE, 40);
    join
  endtask

  task automatic t_reset();
    fork
      i_mem_ctrl_model.issue(4'b1111, 1'b0, 1);
      wait_state(ST_PRE_PD, 40);
    join
    @(posedge clk);
    #2;
    reset_n = 1'b0;
    wait_state(ST_RESET, 10);
    @(posedge clk);
    #2;
    reset_n = 1'b1;
    i_mem_ctrl_model.issue(4'b1111, 1'b1, 1);
    @(posedge clk);
    #2;
    rst = 1'b1;
    @(posedge clk);
    #2;
    rst = 1'b0;
    chk(32'(row), 32'h0, "row cleared by reset");
  endtask

  initial
  begin
    rst = 1'b1;
    reset_n = 1'b1;
    bank_open = 1'b0;
    pd_fast = 1'b0;
    dll_dis = 1'b0;
    repeat (10) @(posedge clk);
    #2;
    rst = 1'b0;
    t_refresh();
    t_self_refresh();
    t_power_down(1'b1, 1'b0, ST_ACT_PD, 1'b1);
    t_power_down(1'b0, 1'b1, ST_PRE_PD, 1'b1);
    t_power_down(1'b0, 1'b0, ST_PRE_PD, 1'b0);
    t_reset();
    conclude();
  end
endmodule
